// ===== hw/appliance_responder.sv
/*
 * Appliance-side responder for the adapter start-up command exchange.
 * It answers inquiry-completion, start-up and object-designated inquiry
 * requests with response frames and flags when initialisation must restart.
 * Assumes byte streams from and to a serial port on the same clock, and
 * that the user side loads object slots and reports the appliance state.
 */
// Behaviour
// - Completion request is answered with 0x81; result OK or 0xFFFF.
// - Completion reporting invalid makes the appliance restart initialisation.
// - Frames open with start octet 0x02 and frame type 0x0002.
// - Response echoes the request tag, or 0x00 when unimplemented.
// - Start-up request is answered with 0x82, length 2, OK or 0xFFFF.
// - Start-up reporting failure makes the appliance restart initialisation.
// - Object inquiry answered with 0x83; accepted, net down, rejected, absent.
// - State mismatch results 0x0101, 0x0103, 0x0105; else 0xFFFF.
// - Object response count field is always 0x01, then object data.
// - Each class code carries its one-octet id and the total count.
// - Object inquiry is mandatory only when four or more objects exist.
// - Only the adapter originates requests; the appliance only responds.
`timescale 1ns/1ps
module appliance_responder
  import frame_pkg::*;
#(
  parameter int OBJ_MAX    = 4,
  parameter bit OBJ_INQ_EN = 1'b1,
  parameter int ADDR_W     = $clog2(OBJ_MAX) + SLOT_AW
)(
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_valid,
  output      logic [7:0]        tx_data,
  output      logic              tx_valid,
  input  wire logic              tx_ready,
  input  wire appl_state_e       appl_state,
  input  wire logic              network_up,
  input  wire logic              inquiry_reject,
  input  wire logic [7:0]        obj_total,
  input  wire logic              obj_wr_en,
  input  wire logic [ADDR_W-1:0] obj_wr_addr,
  input  wire logic [7:0]        obj_wr_data,
  output      logic              restart_init,
  output      logic              inquiry_done,
  output      logic              adapter_started,
  output      logic              frame_error,
  output      logic              busy
);

  localparam int SW = ADDR_W - SLOT_AW;

  typedef enum {
    TX_IDLE, TX_LEN_HI, TX_LEN_LO, TX_LEN_DONE, TX_SEND
  } tx_phase_e;

  typedef struct packed {
    tx_phase_e   phase;
    logic [7:0]  rsp;
    logic [7:0]  tag;
    logic [15:0] len;
    logic [15:0] result;
    logic [7:0]  obj_id;
    logic [7:0]  obj_count;
    logic        with_data;
    logic [15:0] pos;
    logic        rd_ok;
    logic [7:0]  sum;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        restart_init;
    logic        inquiry_done;
    logic        adapter_started;
    logic        frame_error;
    logic        busy;
  } ctl_s;

  ctl_s s;
  ctl_s next_s;

  req_s              req;
  logic              req_valid;
  logic              frame_bad;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic [SW-1:0]     slot;
  logic [15:0]       check_pos;
  logic              need_mem;
  logic              tx_free;
  logic [7:0]        out_byte;

  frame_parser u_parser (
    .clock     (clock),
    .resetn    (resetn),
    .rx_data   (rx_data),
    .rx_valid  (rx_valid),
    .req       (req),
    .req_valid (req_valid),
    .frame_bad (frame_bad)
  );

  obj_store #(
    .ADDR_W (ADDR_W)
  ) u_store (
    .clock   (clock),
    .wr_en   (obj_wr_en),
    .wr_addr (obj_wr_addr),
    .wr_data (obj_wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // Object ids start at one, so slot zero holds the first object.
  assign slot      = SW'(s.obj_id - FIRST_OBJECT_ID);
  assign check_pos = 16'(POS_PAYLOAD + s.len);
  assign tx_free   = !s.tx_valid || tx_ready;
  assign need_mem  = s.with_data && (s.pos >= POS_SLOT) &&
                     (s.pos < check_pos);

  always_comb begin
    if (s.phase == TX_LEN_HI) begin
      rd_addr = {slot, OFS_LEN_HI};
    end else if (s.phase == TX_LEN_LO) begin
      rd_addr = {slot, OFS_LEN_LO};
    end else begin
      rd_addr = {slot, SLOT_AW'(s.pos - POS_SLOT)};
    end
  end

  always_comb begin
    out_byte = 8'h00;
    if (s.pos == check_pos) begin
      out_byte = s.sum;
    end else begin
      case (s.pos)
        POS_START:     out_byte = FRAME_START_OCTET;
        POS_TYPE_HI:   out_byte = FRAME_TYPE_FIELD[15:8];
        POS_TYPE_LO:   out_byte = FRAME_TYPE_FIELD[7:0];
        POS_CMD:       out_byte = s.rsp;
        POS_TAG:       out_byte = s.tag;
        POS_LEN_HI:    out_byte = s.len[15:8];
        POS_LEN_LO:    out_byte = s.len[7:0];
        POS_PAYLOAD:   out_byte = s.result[15:8];
        POS_RES_LO:    out_byte = s.result[7:0];
        POS_OBJ_COUNT: out_byte = OBJ_COUNT_FIELD;
        POS_OBJ_ID:    out_byte = s.obj_id;
        POS_OBJ_TOTAL: out_byte = s.obj_count;
        default:       out_byte = rd_data;
      endcase
    end
  end

  always_comb begin
    next_s              = s;
    next_s.restart_init = 1'b0;
    next_s.frame_error  = frame_bad;
    if (s.tx_valid && tx_ready) begin
      next_s.tx_valid = 1'b0;
    end
    case (s.phase)
      TX_IDLE: begin
        // Frames arrive only from the adapter; nothing is sent unasked.
        if (req_valid) begin
          next_s.tag       = req.tag;
          next_s.len       = LEN_RESULT;
          next_s.result    = RES_OTHER;
          next_s.with_data = 1'b0;
          next_s.pos       = POS_START;
          next_s.rd_ok     = 1'b0;
          next_s.sum       = 8'h00;
          next_s.phase     = TX_SEND;
          if (req.cmd == CMD_INQ_DONE) begin
            next_s.rsp = RSP_INQ_DONE;
            if (req.len == LEN_RESULT) begin
              next_s.result = RES_OK;
              if (req.data == RES_INVALID) begin
                next_s.restart_init    = 1'b1;
                next_s.inquiry_done    = 1'b0;
                next_s.adapter_started = 1'b0;
              end else if (req.data == RES_OK) begin
                next_s.inquiry_done = 1'b1;
              end
            end
          end else if (req.cmd == CMD_STARTUP) begin
            next_s.rsp = RSP_STARTUP;
            if (req.len == LEN_RESULT) begin
              next_s.result = RES_OK;
              if (req.data == RES_INVALID) begin
                next_s.restart_init    = 1'b1;
                next_s.inquiry_done    = 1'b0;
                next_s.adapter_started = 1'b0;
              end else if (req.data == RES_OK) begin
                next_s.adapter_started = 1'b1;
              end
            end
          end else if (req.cmd == CMD_OBJ_INQ) begin
            next_s.rsp       = RSP_OBJ_INQ;
            next_s.obj_id    = req.data[7:0];
            next_s.obj_count = obj_total;
            if (!OBJ_INQ_EN) begin
              next_s.tag = TAG_NOT_IMPL;
            end else if (appl_state == APPL_UNCONFIRMED) begin
              next_s.result = RES_UNCONFIRMED;
            end else if (appl_state == APPL_STANDBY) begin
              next_s.result = RES_STANDBY;
            end else if (appl_state == APPL_ERROR_STOP) begin
              next_s.result = RES_ERROR_STOP;
            end else if (req.len != LEN_OBJ_REQ) begin
              next_s.result = RES_OTHER;
            end else if ((req.data[7:0] < FIRST_OBJECT_ID) ||
                         (req.data[7:0] > obj_total) ||
                         (int'(req.data[7:0]) > OBJ_MAX)) begin
              next_s.result = RES_ABSENT;
            end else if (inquiry_reject) begin
              next_s.result = RES_INVALID;
            end else begin
              next_s.result    = network_up ? RES_OK : RES_OK_NET_DOWN;
              next_s.with_data = 1'b1;
              next_s.phase     = TX_LEN_HI;
            end
          end else begin
            next_s.rsp = req.cmd | RSP_FLAG;
            next_s.tag = TAG_NOT_IMPL;
          end
        end
      end
      TX_LEN_HI: begin
        next_s.phase = TX_LEN_LO;
      end
      TX_LEN_LO: begin
        next_s.len   = {rd_data, 8'h00};
        next_s.phase = TX_LEN_DONE;
      end
      TX_LEN_DONE: begin
        next_s.len   = 16'(OBJ_FIXED_LEN + {s.len[15:8], rd_data});
        next_s.phase = TX_SEND;
      end
      TX_SEND: begin
        if (need_mem && !s.rd_ok) begin
          // Slot bytes come from a registered read; wait one cycle.
          next_s.rd_ok = 1'b1;
        end else if (tx_free) begin
          next_s.tx_data  = out_byte;
          next_s.tx_valid = 1'b1;
          next_s.rd_ok    = 1'b0;
          next_s.pos      = 16'(s.pos + 16'h0001);
          if (s.pos != POS_START) begin
            next_s.sum = s.sum ^ out_byte;
          end
          if (s.pos == check_pos) begin
            next_s.phase = TX_IDLE;
          end
        end
      end
      default: next_s.phase = TX_IDLE;
    endcase
    next_s.busy = (next_s.phase != TX_IDLE);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s <= '{phase: TX_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign tx_data         = s.tx_data;
  assign tx_valid        = s.tx_valid;
  assign restart_init    = s.restart_init;
  assign inquiry_done    = s.inquiry_done;
  assign adapter_started = s.adapter_started;
  assign frame_error     = s.frame_error;
  assign busy            = s.busy;

endmodule : appliance_responder

// ===== hw/frame_pkg.sv
/*
 * Constants and types for the appliance side of the adapter start-up
 * command exchange: frame layout, command and result codes, object store
 * layout and the structs that carry requests between the modules.
 * Assumes byte-wide frame streams on the single system clock.
 */
package frame_pkg;

  localparam logic [7:0]  FRAME_START_OCTET = 8'h02;
  localparam logic [15:0] FRAME_TYPE_FIELD  = 16'h0002;

  localparam logic [7:0]  CMD_INQ_DONE = 8'h01;
  localparam logic [7:0]  CMD_STARTUP  = 8'h02;
  localparam logic [7:0]  CMD_OBJ_INQ  = 8'h03;
  localparam logic [7:0]  RSP_INQ_DONE = 8'h81;
  localparam logic [7:0]  RSP_STARTUP  = 8'h82;
  localparam logic [7:0]  RSP_OBJ_INQ  = 8'h83;
  localparam logic [7:0]  RSP_FLAG     = 8'h80;
  localparam logic [7:0]  TAG_NOT_IMPL = 8'h00;

  localparam logic [15:0] LEN_RESULT    = 16'h0002;
  localparam logic [15:0] LEN_OBJ_REQ   = 16'h0001;
  localparam logic [15:0] OBJ_FIXED_LEN = 16'h000A;

  localparam logic [15:0] RES_OK          = 16'h0000;
  localparam logic [15:0] RES_OK_NET_DOWN = 16'h0001;
  localparam logic [15:0] RES_INVALID     = 16'h0011;
  localparam logic [15:0] RES_ABSENT      = 16'h0012;
  localparam logic [15:0] RES_UNCONFIRMED = 16'h0101;
  localparam logic [15:0] RES_STANDBY     = 16'h0103;
  localparam logic [15:0] RES_ERROR_STOP  = 16'h0105;
  localparam logic [15:0] RES_OTHER       = 16'hFFFF;

  localparam logic [7:0]  OBJ_COUNT_FIELD = 8'h01;
  localparam logic [7:0]  FIRST_OBJECT_ID = 8'h01;

  localparam int          SLOT_AW     = 9;
  localparam logic [8:0]  OFS_LEN_HI  = 9'h003;
  localparam logic [8:0]  OFS_LEN_LO  = 9'h004;

  localparam logic [15:0] POS_START     = 16'h0000;
  localparam logic [15:0] POS_TYPE_HI   = 16'h0001;
  localparam logic [15:0] POS_TYPE_LO   = 16'h0002;
  localparam logic [15:0] POS_CMD       = 16'h0003;
  localparam logic [15:0] POS_TAG       = 16'h0004;
  localparam logic [15:0] POS_LEN_HI    = 16'h0005;
  localparam logic [15:0] POS_LEN_LO    = 16'h0006;
  localparam logic [15:0] POS_PAYLOAD   = 16'h0007;
  localparam logic [15:0] POS_RES_LO    = 16'h0008;
  localparam logic [15:0] POS_OBJ_COUNT = 16'h0009;
  localparam logic [15:0] POS_OBJ_ID    = 16'h000A;
  localparam logic [15:0] POS_OBJ_TOTAL = 16'h000B;
  localparam logic [15:0] POS_SLOT      = 16'h000C;

  localparam logic [15:0] PAYLOAD_KEEP = 16'h0002;

  typedef enum logic [1:0] {
    APPL_UNCONFIRMED,
    APPL_STANDBY,
    APPL_ERROR_STOP,
    APPL_READY
  } appl_state_e;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  tag;
    logic [15:0] len;
    logic [15:0] data;
  } req_s;

endpackage : frame_pkg

// ===== hw/frame_parser.sv
/*
 * Receive parser: finds request frames in the incoming byte stream,
 * checks start octet, frame type and check octet, and presents each good
 * request for one cycle.
 * Assumes rx bytes come from logic on the same clock, one per rx_valid.
 */
`timescale 1ns/1ps
module frame_parser
  import frame_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_valid,
  output      req_s       req,
  output      logic       req_valid,
  output      logic       frame_bad
);

  typedef enum {
    RX_HUNT, RX_TYPE_HI, RX_TYPE_LO, RX_CMD, RX_TAG,
    RX_LEN_HI, RX_LEN_LO, RX_DATA, RX_CHECK
  } rx_phase_e;

  typedef struct packed {
    rx_phase_e   phase;
    req_s        req;
    logic [15:0] cnt;
    logic [7:0]  sum;
    logic        req_valid;
    logic        frame_bad;
  } parser_s;

  parser_s s;
  parser_s next_s;

  always_comb begin
    next_s           = s;
    next_s.req_valid = 1'b0;
    next_s.frame_bad = 1'b0;
    if (rx_valid) begin
      next_s.sum = s.sum ^ rx_data;
      case (s.phase)
        RX_HUNT: begin
          next_s.sum = 8'h00;
          if (rx_data == FRAME_START_OCTET) begin
            next_s.phase = RX_TYPE_HI;
          end
        end
        RX_TYPE_HI: begin
          if (rx_data == FRAME_TYPE_FIELD[15:8]) begin
            next_s.phase = RX_TYPE_LO;
          end else begin
            next_s.phase     = RX_HUNT;
            next_s.frame_bad = 1'b1;
          end
        end
        RX_TYPE_LO: begin
          if (rx_data == FRAME_TYPE_FIELD[7:0]) begin
            next_s.phase = RX_CMD;
          end else begin
            next_s.phase     = RX_HUNT;
            next_s.frame_bad = 1'b1;
          end
        end
        RX_CMD: begin
          next_s.req.cmd = rx_data;
          next_s.phase   = RX_TAG;
        end
        RX_TAG: begin
          next_s.req.tag = rx_data;
          next_s.phase   = RX_LEN_HI;
        end
        RX_LEN_HI: begin
          next_s.req.len[15:8] = rx_data;
          next_s.phase         = RX_LEN_LO;
        end
        RX_LEN_LO: begin
          next_s.req.len[7:0] = rx_data;
          next_s.req.data     = 16'h0000;
          next_s.cnt          = 16'h0000;
          if ({s.req.len[15:8], rx_data} == 16'h0000) begin
            next_s.phase = RX_CHECK;
          end else begin
            next_s.phase = RX_DATA;
          end
        end
        RX_DATA: begin
          // Only the leading payload octets matter for requests.
          if (s.cnt < PAYLOAD_KEEP) begin
            next_s.req.data = {s.req.data[7:0], rx_data};
          end
          next_s.cnt = 16'(s.cnt + 16'h0001);
          if (16'(s.cnt + 16'h0001) == s.req.len) begin
            next_s.phase = RX_CHECK;
          end
        end
        RX_CHECK: begin
          next_s.phase = RX_HUNT;
          if (rx_data == s.sum) begin
            next_s.req_valid = 1'b1;
          end else begin
            next_s.frame_bad = 1'b1;
          end
        end
        default: next_s.phase = RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s <= '{phase: RX_HUNT, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign req       = s.req;
  assign req_valid = s.req_valid;
  assign frame_bad = s.frame_bad;

endmodule : frame_parser

// ===== hw/obj_store.sv
/*
 * Object data store: one slot per device object holding the class code,
 * the inquiry data length and the inquiry data, with a registered read.
 * Assumes the user side fills slots before the adapter asks for them.
 */
`timescale 1ns/1ps
module obj_store #(
  parameter int ADDR_W = 11
)(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output      logic [7:0]        rd_data
);

  logic [7:0] mem [0:(1 << ADDR_W) - 1];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : obj_store

// ===== verif/responder_asserts.sv
/*
 * Port checker for the appliance responder: output framing, flag and
 * pulse behaviour.
 * Assumes it is bound onto appliance_responder and sees only its ports.
 */
`timescale 1ns/1ps
module responder_asserts
  import frame_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       restart_init,
  input wire logic       inquiry_done,
  input wire logic       adapter_started,
  input wire logic       frame_error,
  input wire logic       busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_open;
    tx_valid && tx_data == FRAME_START_OCTET;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence

  chk_tx_stands: assert property (
    s_stall |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before it was accepted");
  chk_frame_open: assert property ($rose(busy) |-> ##[1:6] s_open)
    else $error("response did not open with the start octet");
  chk_tx_in_busy: assert property ($rose(tx_valid) |-> busy)
    else $error("byte offered outside a response");
  chk_restart_pulse: assert property (restart_init |=> !restart_init)
    else $error("restart pulse longer than one cycle");
  chk_restart_clear: assert property (
    restart_init |-> busy && !inquiry_done && !adapter_started)
    else $error("restart left flags set or came without a response");
  chk_done_fall: assert property ($fell(inquiry_done) |-> restart_init)
    else $error("completion flag cleared without restart");
  chk_done_rise: assert property ($rose(inquiry_done) |-> busy)
    else $error("completion flag set without a response");
  chk_start_rise: assert property (
    $rose(adapter_started) |-> busy && !restart_init)
    else $error("start-up flag set without an accepted request");
  chk_err_pulse: assert property (frame_error |=> !frame_error)
    else $error("frame error pulse longer than one cycle");
endmodule : responder_asserts

bind appliance_responder responder_asserts u_chk (
  .clock(clock), .resetn(resetn), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .restart_init(restart_init),
  .inquiry_done(inquiry_done), .adapter_started(adapter_started),
  .frame_error(frame_error), .busy(busy)
);

// ===== verif/adapter_model.sv
/*
 * Adapter model: originates request frames and collects response frames.
 * Assumes the responder runs on the same clock; slow makes the sink stall.
 */
`timescale 1ns/1ps
module adapter_model
  import frame_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       slow,
  output      logic [7:0] rx_data,
  output      logic       rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output      logic       tx_ready
);
  logic [3:0] beat;

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    beat = 4'h0;
  end

  always @(posedge clock) begin
    #1;
    beat = beat + 4'h1;
    tx_ready = !slow || beat[1:0] == 2'b00;
  end

  // Only this side ever starts an exchange; bad flips bit 0 of the check octet.
  task automatic send(input logic [7:0] cmd, input logic [7:0] tag,
                      input logic [7:0] pl[$], input bit bad);
    logic [7:0] f[$];
    logic [7:0] chk;
    f = {FRAME_TYPE_FIELD[15:8], FRAME_TYPE_FIELD[7:0], cmd, tag};
    f = {f, 8'h00, 8'(pl.size()), pl};
    chk = 8'h00;
    foreach (f[i]) chk ^= f[i];
    f = {FRAME_START_OCTET, f, chk ^ {7'h00, bad}};
    foreach (f[i]) begin
      @(posedge clock);
      #1;
      rx_data = f[i];
      rx_valid = 1'b1;
    end
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask : send

  task automatic recv(output logic [7:0] q[$]);
    q = {};
    while (q.size() < 7 || q.size() < 8 + {q[5], q[6]}) begin
      @(posedge clock);
      if (tx_valid === 1'b1 && tx_ready) q.push_back(tx_data);
    end
  endtask : recv
endmodule : adapter_model

// ===== verif/testbench.sv
/*
 * Self-checking bench for the appliance responder driven by the adapter
 * model; expected frames are built from the package constants.
 * Assumes one 100 MHz clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module testbench import frame_pkg::*;;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  rx_data, tx_data, obj_total, obj_wr_data;
  logic        rx_valid, tx_valid, tx_ready, network_up, inquiry_reject;
  logic        obj_wr_en, restart_init, inquiry_done, adapter_started;
  logic        frame_error, busy;
  logic [10:0] obj_wr_addr;
  appl_state_e appl_state;
  logic [7:0]  slot [2][8];
  logic [31:0] lfsr = 32'h0000_730d;
  int          err_total = 0;
  int          num_checks = 0;
  int          n_restart = 0;
  int          n_ferr = 0;
  logic [7:0]  t_cmd [7] = '{8'h01, 8'h02, 8'h01, 8'h01, 8'h02, 8'h02, 8'h01};
  logic [15:0] t_res [7] = '{16'h0000, 16'h0000, 16'h0011, 16'h0000,
                             16'h0000, 16'h0011, 16'h0000};
  logic [1:0]  t_flg [7] = '{2'b10, 2'b11, 2'b00, 2'b10, 2'b11, 2'b00, 2'b00};
  logic [7:0]  cmds [4] = '{8'h01, 8'h02, 8'h03, 8'h05};
  logic [7:0]  c;

  always #5 clock = ~clock;

  always @(posedge clock) begin
    if (restart_init === 1'b1) n_restart++;
    if (frame_error === 1'b1) n_ferr++;
  end

  appliance_responder #(.OBJ_MAX(4), .OBJ_INQ_EN(1'b1)) dut (
    .clock(clock), .resetn(resetn), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .appl_state(appl_state), .network_up(network_up),
    .inquiry_reject(inquiry_reject), .obj_total(obj_total),
    .obj_wr_en(obj_wr_en), .obj_wr_addr(obj_wr_addr),
    .obj_wr_data(obj_wr_data), .restart_init(restart_init),
    .inquiry_done(inquiry_done), .adapter_started(adapter_started),
    .frame_error(frame_error), .busy(busy)
  );

  adapter_model u_adapter (
    .clock(clock), .slow(slow), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic void expect_rsp(input logic [7:0] cmd,
                                     input logic [7:0] tag,
                                     input logic [7:0] pl[$],
                                     output logic [7:0] e[$]);
    logic [15:0] res;
    logic [7:0]  id, t, chk;
    logic [7:0]  body[$];
    t = tag;
    res = (pl.size() == 2) ? RES_OK : RES_OTHER;
    id = (pl.size() > 0) ? pl[0] : 8'h00;
    body = {};
    if (cmd == CMD_OBJ_INQ) begin
      if (appl_state == APPL_UNCONFIRMED) res = RES_UNCONFIRMED;
      else if (appl_state == APPL_STANDBY) res = RES_STANDBY;
      else if (appl_state == APPL_ERROR_STOP) res = RES_ERROR_STOP;
      else if (pl.size() != 1) res = RES_OTHER;
      else if (id == 8'h00 || id > obj_total || id > 8'h04)
        res = RES_ABSENT;
      else if (inquiry_reject) res = RES_INVALID;
      else res = network_up ? RES_OK : RES_OK_NET_DOWN;
      if (res <= RES_OK_NET_DOWN) begin
        body = {OBJ_COUNT_FIELD, id, obj_total};
        for (int k = 0; k < 8; k++) body.push_back(slot[id - 8'h01][k]);
      end
    end else if (cmd != CMD_INQ_DONE && cmd != CMD_STARTUP) begin
      t = TAG_NOT_IMPL;
      res = RES_OTHER;
    end
    body = {res[15:8], res[7:0], body};
    e = {FRAME_TYPE_FIELD[15:8], FRAME_TYPE_FIELD[7:0], cmd | RSP_FLAG, t};
    e = {e, 8'h00, 8'(body.size()), body};
    chk = 8'h00;
    foreach (e[i]) chk ^= e[i];
    e = {FRAME_START_OCTET, e, chk};
  endfunction : expect_rsp

  task automatic xfer(input logic [7:0] cmd, input int n, input logic [15:0] d);
    logic [7:0] pl[$], e[$], got[$], tag;
    int         w;
    tag = rnd();
    pl = {};
    if (n >= 1) pl.push_front(d[7:0]);
    if (n == 2) pl.push_front(d[15:8]);
    expect_rsp(cmd, tag, pl, e);
    u_adapter.send(cmd, tag, pl, 1'b0);
    u_adapter.recv(got);
    check(got.size(), e.size());
    foreach (e[i]) check(got[i], e[i]);
    w = 0;
    while (busy !== 1'b0 && w < 50) begin
      step();
      w++;
    end
    check(busy, 1'b0);
    step();
  endtask : xfer

  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end

  initial begin
    appl_state = APPL_READY;
    network_up = 1'b1;
    inquiry_reject = 1'b0;
    obj_total = 8'h02;
    obj_wr_en = 1'b0;
    obj_wr_addr = 11'h000;
    obj_wr_data = 8'h00;
    repeat (6) @(posedge clock);
    #1;
    resetn = 1'b1;
    step();
    check({tx_valid, busy}, 0);
    check({restart_init, inquiry_done, adapter_started}, 0);
    for (int s = 0; s < 2; s++) begin
      for (int o = 0; o < 8; o++) begin
        slot[s][o] = (o == 3) ? 8'h00 : (o == 4) ? 8'h03 : rnd();
        obj_wr_en = 1'b1;
        obj_wr_addr = {2'(s), 9'(o)};
        obj_wr_data = slot[s][o];
        step();
      end
    end
    obj_wr_en = 1'b0;
    foreach (t_cmd[i]) begin
      xfer(t_cmd[i], (i == 6) ? 1 : 2, t_res[i]);
      check({inquiry_done, adapter_started}, t_flg[i]);
    end
    check(n_restart, 2);
    for (int id = 0; id <= 4; id++) xfer(CMD_OBJ_INQ, 1, 16'(id));
    network_up = 1'b0;
    xfer(CMD_OBJ_INQ, 1, 16'h0002);
    inquiry_reject = 1'b1;
    xfer(CMD_OBJ_INQ, 1, 16'h0001);
    inquiry_reject = 1'b0;
    for (int st = 0; st < 3; st++) begin
      appl_state = appl_state_e'(st);
      xfer(CMD_OBJ_INQ, 1, 16'h0001);
    end
    appl_state = APPL_READY;
    u_adapter.send(CMD_INQ_DONE, 8'h55, {8'h00, 8'h00}, 1'b1);
    repeat (20) step();
    check(n_ferr, 1);
    check({busy, tx_valid}, 0);
    slow = 1'b1;
    repeat (40) begin
      c = cmds[rnd() % 4];
      network_up = rnd() > 8'h40;
      xfer(c, (c == CMD_OBJ_INQ) ? 1 : 2, {rnd(), 8'(rnd() % 4)});
    end
    tally_and_finish();
  end
endmodule : testbench
